/* hdl/cbc_consts.vh */
/*
  Constants for the compare and BCD convert unit: register byte offsets,
  field positions, reset values, operation and relation codes.
  Assumes it is included by bare name from every design file that needs it.
*/
// How it works
// - Compare operands with one of six relations
// - Logic result is 1 when relation holds
// - No invert option; use opposite relation instead
// - Word compare treats operands as signed 16-bit
// - Word compare: update result, codes; clear overflow
// - Long compare treats operands as signed 32-bit
// - Long compare: keep binary result, stored overflow
// - Float compare treats operands as real numbers
// - Float compare: update codes and overflows; keep binary
// - Word BCD source is signed three digits
// - BCD-to-binary activate output equals activate input
// - Digit 10..15 raises fault, halts, logs 2521
// - Decimal-to-binary sets result flags, clears either-term
// - Word to BCD; out of range drops activate
// - Word to decimal updates result and overflow flags
// - Long BCD source is signed seven digits
// - No activate input: no conversion, output 0
// - Word widen sign-extends; activate out equals in
// - Word widen sets result flags, clears either-term
`ifndef CBC_CONSTS_VH
`define CBC_CONSTS_VH

// Register byte offsets
`define CBC_OFS_CTRL 8'h00
`define CBC_OFS_OPA 8'h04
`define CBC_OFS_OPB 8'h08
`define CBC_OFS_RES 8'h0c
`define CBC_OFS_STAT 8'h10
`define CBC_OFS_FAULT 8'h14

// Control register fields
`define CBC_CTRL_OP 2:0
`define CBC_CTRL_REL 6:4
`define CBC_CTRL_ACT 8
`define CBC_CTRL_HND 9
`define CBC_CTRL_GO 31

// Status word bit positions
`define CBC_ST_FST 0
`define CBC_ST_LOG 1
`define CBC_ST_OPS 2
`define CBC_ST_OR 3
`define CBC_ST_SOV 4
`define CBC_ST_OVF 5
`define CBC_ST_CCL 6
`define CBC_ST_CCH 7
`define CBC_ST_BIN 8
`define CBC_ST_ACO 9

// Reset values
`define CBC_RST_CTRL 32'h0000_0000
`define CBC_RST_STAT 10'h000

// Fault register: sticky flag and logged event number
`define CBC_FLT_BIT 0
`define CBC_FLT_ID 27:16
`define CBC_EVT_BCD 12'd2521

// Operation codes
`define CBC_OP_WCMP 3'h0
`define CBC_OP_LCMP 3'h1
`define CBC_OP_FCMP 3'h2
`define CBC_OP_BCD2W 3'h3
`define CBC_OP_W2BCD 3'h4
`define CBC_OP_BCD2L 3'h5
`define CBC_OP_WIDEN 3'h6

// Compare operand modes
`define CBC_MODE_WORD 2'h0
`define CBC_MODE_LONG 2'h1
`define CBC_MODE_REAL 2'h2

// Relation codes
`define CBC_REL_EQ 3'h0
`define CBC_REL_NE 3'h1
`define CBC_REL_GT 3'h2
`define CBC_REL_LT 3'h3
`define CBC_REL_GE 3'h4
`define CBC_REL_LE 3'h5

// Largest magnitude for three-digit BCD
`define CBC_BCD3_MAX 17'd999

`endif

/* hdl/cbc_compare.v */
/*
  Combinational comparator: word, long and real operand modes.
  Assumes operands come from registers on the same clock.
*/
`timescale 1ns/1ps
module cbc_compare (
    input wire [1:0] mode,
    input wire [2:0] rel,
    input wire [31:0] a,
    input wire [31:0] b,
    output reg gt,
    output reg lt,
    output reg unord,
    output reg hit
);
`include "cbc_consts.vh"

    // Order-preserving keys for real operands
    wire [31:0] ka = a[31] ? ~a : {1'b1, a[30:0]};
    wire [31:0] kb = b[31] ? ~b : {1'b1, b[30:0]};
    // Both zeros compare equal whatever their sign
    wire zz = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
    // NaN has full exponent and non-zero fraction
    wire na = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
    wire nb = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);

    // Outcome per mode, then relation select
    always @* begin
        gt = 1'b0;
        lt = 1'b0;
        unord = 1'b0;
        case (mode)
            `CBC_MODE_WORD: begin
                gt = $signed(a[15:0]) > $signed(b[15:0]);
                lt = $signed(a[15:0]) < $signed(b[15:0]);
            end
            `CBC_MODE_LONG: begin
                gt = $signed(a) > $signed(b);
                lt = $signed(a) < $signed(b);
            end
            `CBC_MODE_REAL: begin
                unord = na | nb;
                gt = !unord && !zz && (ka > kb);
                lt = !unord && !zz && (ka < kb);
            end
            default: begin
                gt = 1'b0;
            end
        endcase
        // No invert option; unordered makes every relation false
        case (rel)
            `CBC_REL_EQ: hit = !unord && !gt && !lt;
            `CBC_REL_NE: hit = !unord && (gt || lt);
            `CBC_REL_GT: hit = gt;
            `CBC_REL_LT: hit = lt;
            `CBC_REL_GE: hit = !unord && !lt;
            `CBC_REL_LE: hit = !unord && !gt;
            default: hit = 1'b0;
        endcase
    end
endmodule // cbc_compare

/* hdl/cbc_bcd.v */
/*
  Combinational packed BCD converters, word and long widths.
  Assumes the source word comes from a register on the same clock.
*/
`timescale 1ns/1ps
module cbc_bcd (
    input wire [31:0] src,
    output wire [15:0] word_bin,
    output wire [31:0] long_bin,
    output wire word_bad,
    output wire long_bad,
    output wire [15:0] bcd_word,
    output wire bcd_ovf
);
`include "cbc_consts.vh"

    // Digit value of up to seven nibbles, most significant first
    function [31:0] digits_value;
        input [27:0] d;
        integer i;
        begin
            digits_value = 32'h0;
            for (i = 6; i >= 0; i = i - 1)
                digits_value = digits_value * 32'd10 + {28'h0, d[4*i +: 4]};
        end
    endfunction

    // Any nibble holding 10 to 15 is an invalid digit
    function any_bad;
        input [27:0] d;
        integer i;
        begin
            any_bad = 1'b0;
            for (i = 0; i < 7; i = i + 1)
                if (d[4*i +: 4] > 4'd9)
                    any_bad = 1'b1;
        end
    endfunction

    // Shift-add-three turns a ten-bit magnitude into three digits
    function [11:0] dabble;
        input [9:0] v;
        reg [21:0] s;
        integer i;
        integer j;
        begin
            s = {12'h0, v};
            for (i = 0; i < 10; i = i + 1) begin
                for (j = 0; j < 3; j = j + 1)
                    if (s[10+4*j +: 4] > 4'd4)
                        s[10+4*j +: 4] = s[10+4*j +: 4] + 4'd3;
                s = s << 1;
            end
            dabble = s[21:10];
        end
    endfunction

    // Sign lives in the top nibble; any non-zero sign means negative
    wire wneg = (src[15:12] != 4'h0);
    wire lneg = (src[31:28] != 4'h0);
    wire [31:0] wmag = digits_value({16'h0, src[11:0]});
    wire [31:0] lmag = digits_value(src[27:0]);
    assign word_bin = wneg ? 16'h0 - wmag[15:0] : wmag[15:0];
    assign long_bin = lneg ? 32'h0 - lmag : lmag;
    assign word_bad = any_bad({16'h0, src[11:0]});
    assign long_bad = any_bad(src[27:0]);

    // Binary to BCD; seventeen bits hold the magnitude of -32768
    wire bneg = src[15];
    wire [16:0] bmag = bneg ? 17'h0 - {1'b1, src[15:0]} : {1'b0, src[15:0]};
    assign bcd_ovf = bmag > `CBC_BCD3_MAX;
    assign bcd_word = {bneg ? 4'hf : 4'h0, dabble(bmag[9:0])};
endmodule // cbc_bcd

/* hdl/cbc_top.v */
/*
  Compare and BCD convert unit with an AXI4-Lite register slave.
  Software loads operands, writes the control word with the start
  bit, and reads back result, status word and fault record.
  Assumes a single clock, synchronous active-low reset, and a
  well-behaved AXI4-Lite master with one write and one read at a time.
*/
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module cbc_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg activate_output,
    output reg logic_result_bit,
    output reg halted,
    output reg handler_request
);
`include "cbc_consts.vh"

    // Response codes of the bus
    localparam [1:0] RESP_OKAY = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;

    // Software-visible registers
    reg [31:0] ctrl; // Operation, relation, activate input
    reg [31:0] operand_a; // First operand or conversion source
    reg [31:0] operand_b; // Second operand
    reg [31:0] res; // Conversion result
    reg [9:0] stat; // Status word
    reg fault; // Sticky conversion fault, halts execution

    // Start request, one cycle after the control write
    reg start;

    // Write channel holding registers
    reg aw_held; // Address taken, waiting for data
    reg w_held; // Data taken, waiting for address
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // Next values from the execution logic
    reg [9:0] next_stat;
    reg [31:0] next_res;
    reg next_fault;

    // Field views of the control word
    wire [2:0] op = ctrl[`CBC_CTRL_OP];
    wire [2:0] rel = ctrl[`CBC_CTRL_REL];
    wire act = ctrl[`CBC_CTRL_ACT];
    wire hnd = ctrl[`CBC_CTRL_HND];

    // Combinational engines
    wire [1:0] cmp_mode;
    wire cmp_gt;
    wire cmp_lt;
    wire cmp_unord;
    wire cmp_hit;
    wire [15:0] word_bin;
    wire [31:0] long_bin;
    wire word_bad;
    wire long_bad;
    wire [15:0] bcd_word;
    wire bcd_ovf;

    // Operation code picks the operand mode of the comparator
    assign cmp_mode = (op == `CBC_OP_LCMP) ? `CBC_MODE_LONG :
                      (op == `CBC_OP_FCMP) ? `CBC_MODE_REAL : `CBC_MODE_WORD;

    cbc_compare u_cmp (
        .mode(cmp_mode),
        .rel(rel),
        .a(operand_a),
        .b(operand_b),
        .gt(cmp_gt),
        .lt(cmp_lt),
        .unord(cmp_unord),
        .hit(cmp_hit)
    );

    cbc_bcd u_bcd (
        .src(operand_a),
        .word_bin(word_bin),
        .long_bin(long_bin),
        .word_bad(word_bad),
        .long_bad(long_bad),
        .bcd_word(bcd_word),
        .bcd_ovf(bcd_ovf)
    );

    // Condition codes: 10 greater, 01 less, 00 equal, 11 unordered
    function [1:0] cc_code;
        input g;
        input l;
        input u;
        begin
            if (u)
                cc_code = 2'b11;
            else if (g)
                cc_code = 2'b10;
            else if (l)
                cc_code = 2'b01;
            else
                cc_code = 2'b00;
        end
    endfunction

    // Register index check: word aligned and within the map
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `CBC_OFS_FAULT);
        end
    endfunction

    // Byte-lane merge of a write into an old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (s[i])
                    merge[8*i +: 8] = d[8*i +: 8];
        end
    endfunction

    // Execution: flags and result for the requested operation
    always @* begin
        next_stat = stat;
        next_res = res;
        next_fault = 1'b0;
        case (op)
            `CBC_OP_WCMP, `CBC_OP_LCMP, `CBC_OP_FCMP: begin
                next_stat[`CBC_ST_LOG] = cmp_hit;
                next_stat[`CBC_ST_OPS] = cmp_hit;
                {next_stat[`CBC_ST_CCH], next_stat[`CBC_ST_CCL]} =
                    cc_code(cmp_gt, cmp_lt, cmp_unord);
                next_stat[`CBC_ST_OR] = 1'b0;
                next_stat[`CBC_ST_FST] = 1'b1;
                if (op == `CBC_OP_WCMP) begin
                    // Only the word compare writes the binary result
                    next_stat[`CBC_ST_BIN] = cmp_hit;
                    next_stat[`CBC_ST_OVF] = 1'b0;
                end else if (op == `CBC_OP_LCMP) begin
                    next_stat[`CBC_ST_OVF] = 1'b0;
                end else begin
                    // Unordered reals report overflow, stored as well
                    next_stat[`CBC_ST_OVF] = cmp_unord;
                    next_stat[`CBC_ST_SOV] = stat[`CBC_ST_SOV] | cmp_unord;
                end
            end
            `CBC_OP_BCD2W, `CBC_OP_BCD2L: begin
                // Activate output follows the input, even on a fault
                next_stat[`CBC_ST_ACO] = act;
                if (!act) begin
                    next_stat[`CBC_ST_ACO] = 1'b0;
                end else if ((op == `CBC_OP_BCD2W) ? word_bad : long_bad) begin
                    next_fault = 1'b1;
                end else begin
                    next_res = (op == `CBC_OP_BCD2W) ?
                        {{16{word_bin[15]}}, word_bin} : long_bin;
                    next_stat[`CBC_ST_BIN] = 1'b1;
                    next_stat[`CBC_ST_OPS] = 1'b1;
                    next_stat[`CBC_ST_LOG] = 1'b1;
                    next_stat[`CBC_ST_FST] = 1'b1;
                    next_stat[`CBC_ST_OR] = 1'b0;
                end
            end
            `CBC_OP_W2BCD: begin
                if (!act) begin
                    next_stat[`CBC_ST_ACO] = 1'b0;
                end else begin
                    // Out of range: result kept, overflow raised
                    next_stat[`CBC_ST_ACO] = !bcd_ovf;
                    next_stat[`CBC_ST_BIN] = !bcd_ovf;
                    next_stat[`CBC_ST_OPS] = !bcd_ovf;
                    next_stat[`CBC_ST_LOG] = !bcd_ovf;
                    next_stat[`CBC_ST_OVF] = bcd_ovf;
                    next_stat[`CBC_ST_SOV] = stat[`CBC_ST_SOV] | bcd_ovf;
                    next_stat[`CBC_ST_OR] = 1'b0;
                    next_stat[`CBC_ST_FST] = 1'b1;
                    if (!bcd_ovf)
                        next_res = {16'h0, bcd_word};
                end
            end
            `CBC_OP_WIDEN: begin
                next_stat[`CBC_ST_ACO] = act;
                if (act) begin
                    next_res = {{16{operand_a[15]}}, operand_a[15:0]};
                    next_stat[`CBC_ST_BIN] = 1'b1;
                    next_stat[`CBC_ST_OPS] = 1'b1;
                    next_stat[`CBC_ST_LOG] = 1'b1;
                    next_stat[`CBC_ST_FST] = 1'b1;
                    next_stat[`CBC_ST_OR] = 1'b0;
                end
            end
            default: begin
                // Unused operation codes change nothing
                next_res = res;
            end
        endcase
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            // Ready pulses for one cycle per beat
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            // Both halves present: commit and answer
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register file, execution and fault record
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CBC_RST_CTRL;
            operand_a <= 32'h0;
            operand_b <= 32'h0;
            res <= 32'h0;
            stat <= `CBC_RST_STAT;
            fault <= 1'b0;
            start <= 1'b0;
            handler_request <= 1'b0;
        end else begin
            start <= 1'b0;
            handler_request <= 1'b0;
            if (aw_held && w_held) begin
                case (aw_addr)
                    `CBC_OFS_CTRL: begin
                        // Start bit is not stored; it only requests a run
                        ctrl <= merge(ctrl, w_data, w_strb) & 32'h7fff_ffff;
                        start <= w_strb[3] && w_data[`CBC_CTRL_GO];
                    end
                    `CBC_OFS_OPA: operand_a <= merge(operand_a, w_data, w_strb);
                    `CBC_OFS_OPB: operand_b <= merge(operand_b, w_data, w_strb);
                    `CBC_OFS_STAT: begin
                        // Lets software restore a saved status word
                        if (w_strb[0])
                            stat[7:0] <= w_data[7:0];
                        if (w_strb[1])
                            stat[9:8] <= w_data[9:8];
                    end
                    `CBC_OFS_FAULT: begin
                        // Write one to clear; a fault in the same cycle wins
                        if (w_strb[0] && w_data[`CBC_FLT_BIT])
                            fault <= 1'b0;
                    end
                    default: begin
                        // Result and unmapped words ignore writes
                        start <= 1'b0;
                    end
                endcase
            end
            // A raised fault halts every later run until cleared
            if (start && !fault) begin
                stat <= next_stat;
                res <= next_res;
                if (next_fault) begin
                    fault <= 1'b1;
                    handler_request <= hnd;
                end
            end
        end
    end

    // Pins mirror the status word and fault one cycle later
    always @(posedge aclk) begin
        if (!aresetn) begin
            activate_output <= 1'b0;
            logic_result_bit <= 1'b0;
            halted <= 1'b0;
        end else begin
            activate_output <= stat[`CBC_ST_ACO];
            logic_result_bit <= stat[`CBC_ST_LOG];
            halted <= fault;
        end
    end

    // Read channel: one-cycle decode, data held until taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                case (s_axi_araddr)
                    `CBC_OFS_CTRL: s_axi_rdata <= ctrl;
                    `CBC_OFS_OPA: s_axi_rdata <= operand_a;
                    `CBC_OFS_OPB: s_axi_rdata <= operand_b;
                    `CBC_OFS_RES: s_axi_rdata <= res;
                    `CBC_OFS_STAT: s_axi_rdata <= {22'h0, stat};
                    `CBC_OFS_FAULT: s_axi_rdata <= fault ?
                        {4'h0, `CBC_EVT_BCD, 15'h0, 1'b1} : 32'h0;
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // cbc_top

/* verification/cbc_chk_monitor.sv */
/* Port checker for cbc_top: bus handshakes, result pins, halt and handler request.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cbc_chk_monitor (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic activate_output,
    input logic logic_result_bit,
    input logic halted,
    input logic handler_request
);
    logic [3:0] since_w; // Edges since the last data beat, saturating
    // Pins and fault may only move a few edges after a register write
    always_ff @(posedge aclk) begin
        if (!aresetn)
            since_w <= 4'hf;
        else if (s_axi_wready)
            since_w <= 4'h0;
        else if (since_w != 4'hf)
            since_w <= since_w + 4'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write beat taken while response pending");
    a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_handler_pulse: assert property (handler_request |=> !handler_request)
        else $error("handler request longer than one cycle");
    a_handler_halts: assert property (handler_request |-> ##[0:2] halted)
        else $error("handler request without halt");
    a_halt_cause: assert property ($fell(halted) |-> since_w < 4'h6)
        else $error("halt cleared without a write");
    a_logic_cause: assert property ($changed(logic_result_bit) |-> since_w < 4'h6)
        else $error("logic result moved without an operation");
    a_act_cause: assert property ($changed(activate_output) |-> since_w < 4'h6)
        else $error("activate output moved without an operation");
endmodule // cbc_chk_monitor

bind cbc_top cbc_chk_monitor i_cbc_chk_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .activate_output,
    .logic_result_bit, .halted, .handler_request);

/* verification/tb_top.sv */
/* Bench for cbc_top: AXI4-Lite master tasks and scenarios.
   Assumes the design files and cbc_consts.vh are compiled first. */
`timescale 1ns/1ps
`include "cbc_consts.vh"
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic activate_output, logic_result_bit, halted, handler_request;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_errors = 0, checked = 0, cyc = 0;
    logic hnd_seen = 1'b0; // Any handler request pulse so far
    cbc_top i_cbc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .activate_output, .logic_result_bit, .halted,
        .handler_request);
    always #2.5 aclk = ~aclk;
    // About 400 cycles of traffic; the ceiling leaves room for slow answers
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (handler_request)
            hnd_seen <= 1'b1;
        if (cyc == 6000) begin
            n_errors++;
            give_verdict;
        end
    end
    task give_verdict;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each released when taken
    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid | s_axi_wvalid);
        while (!s_axi_bvalid)
            @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] ad);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Status compare ignores the operand state bit
    task st(input logic [31:0] e);
        rd(`CBC_OFS_STAT);
        chk(rv & 32'h0000_03fb, e);
    endtask
    task run(input logic [2:0] op, rel, input logic act, hnd, input logic [31:0] a, b);
        wr(`CBC_OFS_OPA, a);
        wr(`CBC_OFS_OPB, b);
        wr(`CBC_OFS_CTRL, {1'b1, 21'h0, hnd, act, 1'b0, rel, 1'b0, op});
    endtask
    task t_bus;
        st(32'h0);
        wr(8'h18, 32'hffff_ffff);
        chk(rs, 2'b10);
        rd(8'h18);
        chk(rs, 2'b10);
        chk(rv, 32'h0);
        $display("t_bus end");
    endtask
    // Minus two against three: wrong if read as unsigned or long
    task t_word;
        logic [5:0] tv;
        tv = 6'h2a;
        for (int i = 0; i < 6; i++) begin
            run(`CBC_OP_WCMP, i[2:0], 1'b1, 1'b0, 32'h0000_fffe, 32'h0000_0003);
            st({22'h0, 1'b0, tv[i], 2'b01, 4'h0, tv[i], 1'b1});
            chk(logic_result_bit, tv[i]);
        end
        $display("t_word end");
    endtask
    task t_wide;
        wr(`CBC_OFS_STAT, 32'h0000_0138);
        run(`CBC_OP_LCMP, `CBC_REL_GT, 1'b1, 1'b0, 32'h8000_0000, 32'h0000_0001);
        st(32'h0000_0151);
        wr(`CBC_OFS_STAT, 32'h0000_0100);
        run(`CBC_OP_FCMP, `CBC_REL_GT, 1'b1, 1'b0, 32'hbf80_0000, 32'hc000_0000);
        st(32'h0000_0183);
        $display("t_wide end");
    endtask
    task t_conv;
        logic [2:0] op [5];
        logic [31:0] src [5], res [5];
        op = '{`CBC_OP_BCD2W, `CBC_OP_BCD2W, `CBC_OP_BCD2L, `CBC_OP_BCD2L, `CBC_OP_WIDEN};
        src = '{32'h0000_0123, 32'h0000_f999, 32'h0999_9999, 32'hf000_0001, 32'h0000_8000};
        res = '{32'h0000_007b, 32'hffff_fc19, 32'h0098_967f, 32'hffff_ffff, 32'hffff_8000};
        wr(`CBC_OFS_STAT, 32'h0000_00f8);
        for (int i = 0; i < 5; i++) begin
            run(op[i], 3'h0, 1'b1, 1'b0, src[i], 32'h0);
            rd(`CBC_OFS_RES);
            chk(rv, res[i]);
            rd(`CBC_OFS_STAT);
            chk(rv, 32'h0000_03f7);
        end
        run(`CBC_OP_W2BCD, 3'h0, 1'b1, 1'b0, 32'h0000_fc19, 32'h0);
        rd(`CBC_OFS_RES);
        chk(rv[15:0], 16'hf999);
        run(`CBC_OP_BCD2W, 3'h0, 1'b0, 1'b0, 32'h0000_0456, 32'h0);
        rd(`CBC_OFS_RES);
        chk(rv[15:0], 16'hf999);
        chk(activate_output, 1'b0);
        wr(`CBC_OFS_STAT, 32'h0000_0200);
        run(`CBC_OP_W2BCD, 3'h0, 1'b1, 1'b0, 32'h0000_03e8, 32'h0);
        rd(`CBC_OFS_STAT);
        chk(rv, 32'h0000_0031);
        $display("t_conv end");
    endtask
    // A bad digit halts; later starts are ignored until cleared
    task t_fault;
        chk(hnd_seen, 1'b0);
        run(`CBC_OP_BCD2W, 3'h0, 1'b1, 1'b1, 32'h0000_00a0, 32'h0);
        rd(`CBC_OFS_FAULT);
        chk(rv, {4'h0, `CBC_EVT_BCD, 15'h0, 1'b1});
        chk(halted, 1'b1);
        chk(hnd_seen, 1'b1);
        run(`CBC_OP_WIDEN, 3'h0, 1'b1, 1'b0, 32'h0000_0005, 32'h0);
        rd(`CBC_OFS_RES);
        chk(rv[15:0], 16'hf999);
        wr(`CBC_OFS_FAULT, 32'h0000_0001);
        rd(`CBC_OFS_FAULT);
        chk(rv, 32'h0);
        chk(halted, 1'b0);
        $display("t_fault end");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus;
        t_word;
        t_wide;
        t_conv;
        t_fault;
        give_verdict;
    end
endmodule // tb_top
